/* File: common/sstdm_if.sv */
// Serial TDM link between the port and its far party, with pin resolution.
`timescale 1ns/1ns
`include "sstdm_map.svh"
interface sstdm_if;
  sstdm_pkg::sstdm_pins_t dev_o;
  sstdm_pkg::sstdm_pins_t dev_oe;
  sstdm_pkg::sstdm_pins_t far_o;
  sstdm_pkg::sstdm_pins_t far_oe;
  sstdm_pkg::sstdm_pins_t pin;
  localparam sstdm_pkg::sstdm_pins_t PULL = `SSTDM_PULL;

  // An undriven pin settles to its pull level; the frame sync idles low.
  genvar gi;
  for (gi = 0; gi < `SSTDM_PINS; gi++) begin : g_pin
    assign pin[gi] = dev_oe[gi] ? dev_o[gi] : (far_oe[gi] ? far_o[gi] : PULL[gi]);
  end

  wire in_bit_clock = pin[`SSTDM_P_ICK];
  wire in_word_load = pin[`SSTDM_P_ILD];
  wire out_bit_clock = pin[`SSTDM_P_OCK];
  wire out_word_load = pin[`SSTDM_P_OLD];
  wire frame_sync_line = pin[`SSTDM_P_SYNC];
  wire out_enable_n = pin[`SSTDM_P_DOEN];
  wire serial_address_line = pin[`SSTDM_P_SADD];
  wire serial_out_line = pin[`SSTDM_P_DO];
  wire serial_in_line = pin[`SSTDM_P_DI];

  modport dev (output dev_o, output dev_oe, input pin);
  modport far (output far_o, output far_oe, input pin);
endinterface

/* File: common/sstdm_map.svh */
// Pin indices, word layout and timing constants of the serial TDM port.
`ifndef SSTDM_MAP_SVH
`define SSTDM_MAP_SVH

`define SSTDM_WORD_BITS 16
`define SSTDM_BCNT_LAST 4'hF
`define SSTDM_FIFO_DEPTH 8
`define SSTDM_CLK_NS 8
`define SSTDM_BIT_HALF_NS 32
`define SSTDM_BIT_HALF_CYC ((`SSTDM_BIT_HALF_NS + `SSTDM_CLK_NS - 1) / `SSTDM_CLK_NS)
`define SSTDM_SYNC_LAST_8 4'h7
`define SSTDM_SYNC_LAST_16 4'hF

`define SSTDM_PINS 9
`define SSTDM_P_ICK 0
`define SSTDM_P_ILD 1
`define SSTDM_P_OCK 2
`define SSTDM_P_OLD 3
`define SSTDM_P_SYNC 4
`define SSTDM_P_DOEN 5
`define SSTDM_P_SADD 6
`define SSTDM_P_DO 7
`define SSTDM_P_DI 8
`define SSTDM_PULL 9'h1EF

`endif

/* File: common/sstdm_pkg.sv */
// Types shared by both ends of the serial TDM port.
`include "sstdm_map.svh"
package sstdm_pkg;
  typedef logic [`SSTDM_WORD_BITS-1:0] sstdm_word_t;
  typedef logic [`SSTDM_PINS-1:0] sstdm_pins_t;
endpackage

/* File: hdl/sstdm_dev.sv */
// Device end of the serial TDM port, with its transmit FIFO.
//
// Notes on behaviour
// R1 - Input bit sampled on rising clock, selected order.
// R2 - Input bit clock driven when active, else received.
// R3 - Input load moves shift word; falling starts word.
// R4 - Input full set on load, cleared read/reset.
// R5 - Output shifts in selected order on rising clock.
// R6 - Edge select moves output change to falling edge.
// R7 - Serial output released while output enable high.
// R8 - Outside TDM, enable is input gating outputs.
// R9 - TDM mode drives enable low in own slot.
// R10 - Output bit clock driven when active, else received.
// R11 - Output load moves buffer into shift register.
// R12 - Output load driven when active, else received.
// R13 - Empty set on load, cleared on buffer write.
// R14 - Reset sets the output empty flag.
// R15 - TDM address stream driven only in own slot.
// R16 - Outside TDM, address line is second output.
// R17 - Address line released while enable high; pulled up.
// R18 - Sync falling edge restarts load strobe generators. The code skips the restart when it is the TDM sync master.
// R19 - Sync master drives sync, transmits slot zero.
// R20 - Master sync period is 8 or 16 words.
// R21 - Far party holds sync low outside TDM.
// R22 - Sixteen bit words between consecutive load strobes.
`timescale 1ns/1ns
`include "sstdm_map.svh"

module sstdm_fifo #(
  parameter int unsigned WIDTH = `SSTDM_WORD_BITS,
  parameter int unsigned DEPTH = `SSTDM_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least two.");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;

  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = (wp_r == rp_r);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_r + (AW+1)'(push);
      rp_r <= rp_r + (AW+1)'(pop);
    end
  end
endmodule

module sstdm_dev #(
  parameter int unsigned HALF_CYC = `SSTDM_BIT_HALF_CYC,
  parameter int unsigned FIFO_DEPTH = `SSTDM_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration
  input wire logic msb_first_i,
  input wire logic in_clk_active_i,
  input wire logic in_load_active_i,
  input wire logic out_clk_active_i,
  input wire logic out_load_active_i,
  input wire logic out_edge_select_i,
  input wire logic tdm_mode_i,
  input wire logic tdm_sync_master_i,
  input wire logic sync_period_select_i,
  input wire logic [3:0] tdm_slot_i,
  // Software input side
  input wire logic rd_strobe_i,
  output sstdm_pkg::sstdm_word_t rd_data_o,
  output logic in_buffer_full_flag_o,
  // Software output side
  input wire logic wr_valid_i,
  input wire sstdm_pkg::sstdm_word_t wr_data_i,
  output logic wr_ready_o,
  input wire sstdm_pkg::sstdm_word_t addr_word_i,
  output logic out_buffer_empty_flag_o,
  // Link
  sstdm_if.dev lnk
);
  if (HALF_CYC < 1 || HALF_CYC > 65535) begin : g_bad_half
    $error("Bit clock half period must be 1 to 65535 cycles.");
  end
  // Pins pass two flip-flops; edges wait until the chain holds real pin samples.
  sstdm_pkg::sstdm_pins_t s1_r;
  sstdm_pkg::sstdm_pins_t s2_r;
  sstdm_pkg::sstdm_pins_t p_r;
  logic [2:0] arm_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_r <= `SSTDM_PULL;
      s2_r <= `SSTDM_PULL;
      p_r <= `SSTDM_PULL;
      arm_r <= 3'h0;
    end else begin
      s1_r <= lnk.pin;
      s2_r <= s1_r;
      p_r <= s2_r;
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end
  wire sstdm_pkg::sstdm_pins_t rise = s2_r & ~p_r & {`SSTDM_PINS{arm_r[2]}};
  wire sstdm_pkg::sstdm_pins_t fall = ~s2_r & p_r & {`SSTDM_PINS{arm_r[2]}};
  wire ick_rise = rise[`SSTDM_P_ICK];
  wire ild_fall = fall[`SSTDM_P_ILD];
  wire old_fall = fall[`SSTDM_P_OLD];
  wire sync_fall = fall[`SSTDM_P_SYNC];
  wire sh_edge = out_edge_select_i ? fall[`SSTDM_P_OCK] : rise[`SSTDM_P_OCK];
  // Strobe generator for active clocks, loads and master frame sync.
  logic [15:0] half_r;
  logic gclk_r;
  logic [3:0] bcnt_r;
  logic [3:0] fcnt_r;
  wire [3:0] sync_last = sync_period_select_i ? `SSTDM_SYNC_LAST_16 : `SSTDM_SYNC_LAST_8;
  wire tick = (half_r == 16'(HALF_CYC - 1));
  wire resync = sync_fall && !(tdm_mode_i && tdm_sync_master_i);
  wire word_end = tick && gclk_r && (bcnt_r == `SSTDM_BCNT_LAST);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || resync) begin // R18
      half_r <= '0;
      gclk_r <= 1'b0;
      bcnt_r <= '0;
      fcnt_r <= '0;
    end else begin
      half_r <= tick ? 16'h0000 : half_r + 16'h0001;
      if (tick) begin
        gclk_r <= !gclk_r;
      end
      if (tick && gclk_r) begin
        bcnt_r <= bcnt_r + 4'h1; // R22
      end
      if (word_end) begin
        fcnt_r <= (fcnt_r >= sync_last) ? 4'h0 : fcnt_r + 4'h1; // R20
      end
    end
  end
  wire gen_load = (bcnt_r != 4'h0);
  wire gen_sync = (fcnt_r != 4'h0);
  // Input section.
  sstdm_pkg::sstdm_word_t isr_r;
  sstdm_pkg::sstdm_word_t ibuf_r;
  logic ibf_r;
  wire di = s2_r[`SSTDM_P_DI];
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      isr_r <= '0;
      ibuf_r <= '0;
      ibf_r <= 1'b0; // R4
    end else begin
      if (ick_rise) begin
        isr_r <= msb_first_i ? {isr_r[14:0], di} : {di, isr_r[15:1]}; // R1
      end
      if (ild_fall) begin
        ibuf_r <= isr_r; // R3
      end
      ibf_r <= ild_fall || (ibf_r && !rd_strobe_i); // R4
    end
  end
  assign rd_data_o = ibuf_r;
  assign in_buffer_full_flag_o = ibf_r;

  // Output section, fed by the FIFO.
  logic f_valid;
  sstdm_pkg::sstdm_word_t f_data;
  sstdm_pkg::sstdm_word_t obuf_r;
  sstdm_pkg::sstdm_word_t osr_r;
  sstdm_pkg::sstdm_word_t asr_r;
  logic obe_r;
  logic first_r;
  wire take = f_valid && obe_r && !old_fall;

  sstdm_fifo #(.WIDTH(`SSTDM_WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(wr_valid_i),
    .in_data_i(wr_data_i),
    .in_ready_o(wr_ready_o),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(take)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      obuf_r <= '0;
      osr_r <= '0;
      asr_r <= '0;
      obe_r <= 1'b1; // R14
      first_r <= 1'b0;
    end else if (old_fall) begin
      osr_r <= obuf_r; // R11
      asr_r <= addr_word_i;
      obe_r <= 1'b1; // R13
      first_r <= !out_edge_select_i;
    end else begin
      if (take) begin
        obuf_r <= f_data;
        obe_r <= 1'b0; // R13
      end
      if (sh_edge && first_r) begin
        first_r <= 1'b0;
      end else if (sh_edge) begin
        osr_r <= msb_first_i ? {osr_r[14:0], 1'b0} : {1'b0, osr_r[15:1]}; // R5 R6
        asr_r <= msb_first_i ? {asr_r[14:0], 1'b0} : {1'b0, asr_r[15:1]};
      end
    end
  end
  assign out_buffer_empty_flag_o = obe_r;

  // Time slot tracking from the word loads seen on the link.
  logic [3:0] scnt_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || sync_fall) begin
      scnt_r <= '0;
    end else if (old_fall) begin
      scnt_r <= (scnt_r >= sync_last) ? 4'h0 : scnt_r + 4'h1;
    end
  end
  wire [3:0] my_slot_no = tdm_sync_master_i ? 4'h0 : tdm_slot_i; // R19
  wire my_slot = (scnt_r == my_slot_no);
  wire out_en = tdm_mode_i ? my_slot : !s2_r[`SSTDM_P_DOEN]; // R8 R9
  wire obit = msb_first_i ? osr_r[15] : osr_r[0];
  wire abit = msb_first_i ? asr_r[15] : asr_r[0];

  assign lnk.dev_o[`SSTDM_P_ICK] = gclk_r;
  assign lnk.dev_oe[`SSTDM_P_ICK] = in_clk_active_i; // R2
  assign lnk.dev_o[`SSTDM_P_ILD] = gen_load;
  assign lnk.dev_oe[`SSTDM_P_ILD] = in_load_active_i; // R3
  assign lnk.dev_o[`SSTDM_P_OCK] = gclk_r;
  assign lnk.dev_oe[`SSTDM_P_OCK] = out_clk_active_i; // R10
  assign lnk.dev_o[`SSTDM_P_OLD] = gen_load;
  assign lnk.dev_oe[`SSTDM_P_OLD] = out_load_active_i; // R12
  assign lnk.dev_o[`SSTDM_P_SYNC] = gen_sync;
  assign lnk.dev_oe[`SSTDM_P_SYNC] = tdm_mode_i && tdm_sync_master_i; // R19
  assign lnk.dev_o[`SSTDM_P_DOEN] = 1'b0;
  assign lnk.dev_oe[`SSTDM_P_DOEN] = tdm_mode_i && my_slot; // R9
  assign lnk.dev_o[`SSTDM_P_SADD] = !abit;
  assign lnk.dev_oe[`SSTDM_P_SADD] = out_en; // R15 R16 R17
  assign lnk.dev_o[`SSTDM_P_DO] = obit;
  assign lnk.dev_oe[`SSTDM_P_DO] = out_en; // R7
  assign lnk.dev_o[`SSTDM_P_DI] = 1'b0;
  assign lnk.dev_oe[`SSTDM_P_DI] = 1'b0;
endmodule

/* File: hdl/sstdm_far.sv */
// Far party of the serial TDM port: codec-like peer on the link.
`timescale 1ns/1ns
`include "sstdm_map.svh"

module sstdm_far #(
  parameter int unsigned HALF_CYC = `SSTDM_BIT_HALF_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration
  input wire logic drive_clocks_i,
  input wire logic tdm_i,
  input wire logic doen_n_i,
  input wire logic msb_first_i,
  input wire logic sample_rise_i,
  // Transmit toward the device
  input wire logic tx_valid_i,
  input wire sstdm_pkg::sstdm_word_t tx_data_i,
  output logic tx_ready_o,
  // Receive from the device
  output sstdm_pkg::sstdm_word_t rx_data_o,
  output logic rx_valid_o,
  // Link
  sstdm_if.far lnk
);
  if (HALF_CYC < 1 || HALF_CYC > 65535) begin : g_bad_half
    $error("Bit clock half period must be 1 to 65535 cycles.");
  end

  sstdm_pkg::sstdm_pins_t s1_r;
  sstdm_pkg::sstdm_pins_t s2_r;
  sstdm_pkg::sstdm_pins_t p_r;
  logic [2:0] arm_r;
  // Edges wait until the chain holds real pin samples, so the reset fill cannot fake one.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_r <= `SSTDM_PULL;
      s2_r <= `SSTDM_PULL;
      p_r <= `SSTDM_PULL;
      arm_r <= 3'h0;
    end else begin
      s1_r <= lnk.pin;
      s2_r <= s1_r;
      p_r <= s2_r;
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end
  wire sstdm_pkg::sstdm_pins_t rise = s2_r & ~p_r & {`SSTDM_PINS{arm_r[2]}};
  wire sstdm_pkg::sstdm_pins_t fall = ~s2_r & p_r & {`SSTDM_PINS{arm_r[2]}};
  wire ild_fall = fall[`SSTDM_P_ILD];
  wire old_fall = fall[`SSTDM_P_OLD];
  wire ick_fall = fall[`SSTDM_P_ICK];
  wire smp = sample_rise_i ? rise[`SSTDM_P_OCK] : fall[`SSTDM_P_OCK];

  // Clock and load generator used when this party owns the clocks.
  logic [15:0] half_r;
  logic gclk_r;
  logic [3:0] bcnt_r;
  wire tick = (half_r == 16'(HALF_CYC - 1));
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      half_r <= '0;
      gclk_r <= 1'b0;
      bcnt_r <= '0;
    end else begin
      half_r <= tick ? 16'h0000 : half_r + 16'h0001;
      if (tick) begin
        gclk_r <= !gclk_r;
      end
      if (tick && gclk_r) begin
        bcnt_r <= bcnt_r + 4'h1;
      end
    end
  end

  // Transmit: a word starts at each input load, bits change on falling edges.
  sstdm_pkg::sstdm_word_t hold_r;
  sstdm_pkg::sstdm_word_t tsr_r;
  logic full_r;
  wire accept = tx_valid_i && !full_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hold_r <= '0;
      tsr_r <= '0;
      full_r <= 1'b0;
    end else begin
      if (accept) begin
        hold_r <= tx_data_i;
      end
      full_r <= accept || (full_r && !ild_fall);
      if (ild_fall) begin
        tsr_r <= full_r ? hold_r : '0;
      end else if (ick_fall) begin
        tsr_r <= msb_first_i ? {tsr_r[14:0], 1'b0} : {1'b0, tsr_r[15:1]};
      end
    end
  end
  assign tx_ready_o = !full_r;

  // Receive: the word completes at the next output load.
  sstdm_pkg::sstdm_word_t rsr_r;
  sstdm_pkg::sstdm_word_t rsr_nxt;
  logic rxv_r;
  wire rbit = s2_r[`SSTDM_P_DO];
  always_comb begin
    rsr_nxt = rsr_r;
    if (smp) begin
      rsr_nxt = msb_first_i ? {rsr_r[14:0], rbit} : {rbit, rsr_r[15:1]};
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rsr_r <= '0;
      rx_data_o <= '0;
      rxv_r <= 1'b0;
    end else begin
      rsr_r <= rsr_nxt;
      rxv_r <= old_fall;
      if (old_fall) begin
        rx_data_o <= rsr_nxt;
      end
    end
  end
  assign rx_valid_o = rxv_r;

  wire gen_load = (bcnt_r != 4'h0);
  assign lnk.far_o[`SSTDM_P_ICK] = gclk_r;
  assign lnk.far_oe[`SSTDM_P_ICK] = drive_clocks_i; // R2
  assign lnk.far_o[`SSTDM_P_ILD] = gen_load;
  assign lnk.far_oe[`SSTDM_P_ILD] = drive_clocks_i; // R3
  assign lnk.far_o[`SSTDM_P_OCK] = gclk_r;
  assign lnk.far_oe[`SSTDM_P_OCK] = drive_clocks_i; // R10
  assign lnk.far_o[`SSTDM_P_OLD] = gen_load;
  assign lnk.far_oe[`SSTDM_P_OLD] = drive_clocks_i; // R12
  assign lnk.far_o[`SSTDM_P_SYNC] = 1'b0;
  assign lnk.far_oe[`SSTDM_P_SYNC] = !tdm_i; // R21
  assign lnk.far_o[`SSTDM_P_DOEN] = doen_n_i;
  assign lnk.far_oe[`SSTDM_P_DOEN] = !tdm_i; // R8
  assign lnk.far_o[`SSTDM_P_SADD] = 1'b0;
  assign lnk.far_oe[`SSTDM_P_SADD] = 1'b0;
  assign lnk.far_o[`SSTDM_P_DO] = 1'b0;
  assign lnk.far_oe[`SSTDM_P_DO] = 1'b0;
  assign lnk.far_o[`SSTDM_P_DI] = msb_first_i ? tsr_r[15] : tsr_r[0];
  assign lnk.far_oe[`SSTDM_P_DI] = 1'b1;
endmodule

/* File: tb/sstdm_monitor.sv */
// Concurrent checks on the pins of the serial TDM link.
`timescale 1ns/1ns
module sstdm_monitor #(
  parameter int unsigned HALF_CYC = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link signals
  input wire sstdm_pkg::sstdm_pins_t dev_o,
  input wire sstdm_pkg::sstdm_pins_t dev_oe,
  input wire sstdm_pkg::sstdm_pins_t pin
);
  localparam int unsigned GAP = 32 * HALF_CYC - 1;
  sstdm_pkg::sstdm_pins_t prev_r;
  logic [7:0] igap_r;
  logic [7:0] ogap_r;
  logic [4:0] nold_r;
  logic iseen_r;
  logic oseen_r;
  logic sseen_r;
  wire ifall = dev_oe[1] & prev_r[1] & ~pin[1];
  wire ofall = dev_oe[3] & prev_r[3] & ~pin[3];
  wire sfall = prev_r[4] & ~pin[4];

  // A sync fall may restart the strobe generators, so spacing is judged afresh after it.
  always_ff @(posedge clk_i) begin
    prev_r <= pin;
    igap_r <= ifall ? 8'h00 : igap_r + 8'h01;
    ogap_r <= ofall ? 8'h00 : ogap_r + 8'h01;
    nold_r <= sfall ? {4'h0, ofall} : nold_r + {4'h0, ofall};
    iseen_r <= rst_n_i & (iseen_r | ifall) & ~sfall;
    oseen_r <= rst_n_i & (oseen_r | ofall) & ~sfall;
    sseen_r <= rst_n_i & (sseen_r | sfall);
  end

  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence en_high_s;
    pin[5] [*6];
  endsequence

  a_do_release: assert property (en_high_s |-> !dev_oe[7])
    else $error("serial out driven while enable is high");
  a_addr_release: assert property (en_high_s |-> !dev_oe[6])
    else $error("address line driven while enable is high");
  a_in_clk_half: assert property (dev_oe[0] && $changed(dev_o[0]) |=> $stable(dev_o[0]) [*3])
    else $error("input bit clock half period wrong");
  a_out_clk_half: assert property (dev_oe[2] && $changed(dev_o[2]) |=> $stable(dev_o[2]) [*3])
    else $error("output bit clock half period wrong");
  a_in_word_gap: assert property (ifall && iseen_r |-> igap_r == GAP[7:0])
    else $error("input load strobes not one word apart");
  a_out_word_gap: assert property (ofall && oseen_r |-> ogap_r == GAP[7:0])
    else $error("output load strobes not one word apart");
  a_in_load_edge: assert property (ifall && dev_oe[0] |-> prev_r[0] && !pin[0])
    else $error("input load did not fall with the bit clock");
  a_sync_frame: assert property (sfall && sseen_r && dev_oe[4] |->
    nold_r == 5'h08 || nold_r == 5'h10)
    else $error("frame sync period is not 8 or 16 words");
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for both ends of the serial TDM port.
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned HC = 4;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic msb = 1'b0, act = 1'b1, oedge = 1'b0, tdm = 1'b0, mst = 1'b0, sps = 1'b0;
  logic rd_strobe = 1'b0, wr_valid = 1'b0, doen_n = 1'b0, fmsb = 1'b0, tx_valid = 1'b0;
  logic [3:0] slot = 4'h0;
  sstdm_pkg::sstdm_word_t wr_data = 16'h0000, addr_word = 16'h0000, tx_data = 16'h0000;
  sstdm_pkg::sstdm_word_t rd_data, rx_data, last;
  sstdm_pkg::sstdm_word_t q[$];
  logic ibf, wr_ready, obe, tx_ready, rx_valid;
  logic sb_on = 1'b0;
  int fail_count = 0;
  int n_checks = 0;
  int seed = 32'hEE88;

  sstdm_if lnk ();
  always #4 clk_i = ~clk_i;

  sstdm_dev #(.HALF_CYC(HC), .FIFO_DEPTH(8)) i_sstdm_dev (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .msb_first_i(msb), .in_clk_active_i(act),
    .in_load_active_i(act), .out_clk_active_i(act), .out_load_active_i(act),
    .out_edge_select_i(oedge), .tdm_mode_i(tdm), .tdm_sync_master_i(mst),
    .sync_period_select_i(sps), .tdm_slot_i(slot), .rd_strobe_i(rd_strobe),
    .rd_data_o(rd_data), .in_buffer_full_flag_o(ibf), .wr_valid_i(wr_valid),
    .wr_data_i(wr_data), .wr_ready_o(wr_ready), .addr_word_i(addr_word),
    .out_buffer_empty_flag_o(obe), .lnk(lnk.dev));
  sstdm_far #(.HALF_CYC(HC)) i_sstdm_far (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .drive_clocks_i(!act), .tdm_i(tdm),
    .doen_n_i(doen_n), .msb_first_i(fmsb), .sample_rise_i(oedge), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .lnk(lnk.far));
  sstdm_monitor #(.HALF_CYC(HC)) i_sstdm_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe), .pin(lnk.pin));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task automatic tmo(input logic ok, input string what);
    check(ok, what);
    if (ok !== 1'b1) report_and_stop();
  endtask

  task automatic do_reset(input int n);
    rst_n_i = 1'b0;
    repeat (n) @(negedge clk_i);
    rst_n_i = 1'b1;
  endtask

  // A word as seen by the receiving end: unchanged when both ends use one bit order, bit-reversed when they disagree.
  function automatic sstdm_pkg::sstdm_word_t xf(input sstdm_pkg::sstdm_word_t w);
    for (int i = 0; i < 16; i++) xf[i] = (msb == fmsb) ? w[i] : w[15 - i];
  endfunction

  // Between queued words the far end sees the previous word sent again.
  always @(negedge clk_i) begin
    if (sb_on && rx_valid === 1'b1) begin
      if (q.size() > 0 && rx_data === q[0]) begin
        last = q.pop_front();
      end else begin
        check(rx_data === last, "unexpected word at far end");
      end
    end
  end

  initial begin
    int k, f, t0;
    logic pv, own;
    sstdm_pkg::sstdm_word_t w;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    check(ibf === 1'b0 && obe === 1'b1, "flags after reset");
    check(wr_ready === 1'b1 && rd_data === 16'h0000, "buffers after reset");
    for (int c = 0; c < 8; c++) begin
      msb = c[0];
      oedge = c[1];
      act = !c[2];
      fmsb = 1'($random(seed));
      addr_word = 16'($random(seed));
      slot = 4'($random(seed));
      do_reset(3);
      last = 16'h0000;
      q.delete();
      sb_on = 1'b1;
      repeat (8) @(negedge clk_i);
      check(lnk.dev_oe[7] === 1'b1 && lnk.dev_oe[6] === 1'b1, "outputs not driven");
      check(lnk.frame_sync_line === 1'b0, "frame sync not held low");
      check(ibf === 1'b0, "full flag raised after reset");
      for (k = 0; k < 20 && wr_ready === 1'b1; k++) begin
        w = 16'($random(seed));
        wr_valid = 1'b1;
        wr_data = w;
        q.push_back(xf(w));
        @(negedge clk_i);
      end
      wr_valid = 1'b0;
      check(k >= 8 && k < 20, "fifo did not refuse when full");
      check(obe === 1'b0, "empty flag after write");
      for (k = 0; k < 300 && obe !== 1'b1; k++) @(negedge clk_i);
      tmo(obe === 1'b1, "no output load after write");
      check(lnk.serial_address_line === !(msb ? addr_word[15] : addr_word[0]), "address bit");
      w = 16'($random(seed));
      for (k = 0; k < 300 && tx_ready !== 1'b1; k++) @(negedge clk_i);
      tmo(tx_ready === 1'b1, "far end never ready to send");
      tx_valid = 1'b1;
      tx_data = w;
      @(negedge clk_i);
      tx_valid = 1'b0;
      for (k = 0; k < 600 && rd_data !== xf(w); k++) @(negedge clk_i);
      tmo(rd_data === xf(w), "word not received by device");
      @(negedge clk_i);
      check(ibf === 1'b1, "full flag on receipt");
      rd_strobe = 1'b1;
      @(negedge clk_i);
      rd_strobe = 1'b0;
      @(negedge clk_i);
      check(ibf === 1'b0, "full flag after read");
      for (k = 0; k < 3000 && q.size() > 0; k++) @(negedge clk_i);
      tmo(q.size() == 0, "words lost on the link");
      for (k = 0; k < 300 && obe !== 1'b1; k++) @(negedge clk_i);
      tmo(obe === 1'b1, "empty flag after last load");
      sb_on = 1'b0;
      doen_n = 1'b1;
      repeat (8) @(negedge clk_i);
      check(lnk.dev_oe[7] === 1'b0 && lnk.dev_oe[6] === 1'b0, "outputs not released");
      doen_n = 1'b0;
    end
    tdm = 1'b1;
    mst = 1'b1;
    act = 1'b1;
    sps = 1'($random(seed));
    do_reset(3);
    f = 0;
    t0 = 0;
    pv = 1'b0;
    own = 1'b0;
    for (k = 0; k < 6000 && f < 2; k++) begin
      @(negedge clk_i);
      if (pv === 1'b1 && lnk.frame_sync_line === 1'b0) begin
        f++;
        if (f == 1) t0 = k;
      end
      if (f == 1 && lnk.dev_oe[5] === 1'b1 && lnk.dev_o[5] === 1'b0) own = 1'b1;
      pv = lnk.frame_sync_line;
    end
    tmo(f == 2, "no frame sync from master");
    check(k - 1 - t0 == (sps ? 2048 : 1024), "frame sync period");
    check(own === 1'b1 && lnk.dev_oe[4] === 1'b1, "master slot not signalled");
    // Let the monitor judge the second frame sync fall before the run ends.
    repeat (4) @(negedge clk_i);
    report_and_stop();
  end
endmodule
